// [irrs_pkg.sv]
// Behaviour
// - The transceiver has no mode after power-up, so the host sets a rate mode before any traffic.
// - The host leaves the static rate pin undriven when it is unused or the device is in standby.
// - A programming sequence starts by raising the shutdown/mode input before setting transmit data.
// - Transmit data carries the wanted mode and stays stable at least 200 ns before shutdown/mode falls.
// - After a high-bandwidth request transmit data stays high at least 200 ns after the falling edge.
// - After a low-bandwidth request transmit data stays low at least 200 ns after the falling edge.
package irrs_pkg;
   localparam int unsigned CLK_FREQ_HZ  = 25_000_000;
   localparam int unsigned T_SETUP_NS   = 200;
   localparam int unsigned T_HOLD_NS    = 200;
   localparam int unsigned T_HIGH_NS    = 200;
   localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_FREQ_HZ;
   localparam int unsigned SETUP_CYC =
      (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned HOLD_CYC  =
      (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned HIGH_CYC  =
      (T_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W     = 4;
   localparam logic [3:0]  CNT_ZERO  = 4'h0;
   localparam logic        MODE_LOW  = 1'b0;
   localparam logic        MODE_HIGH = 1'b1;

   typedef enum logic [2:0] {
      IRRS_IDLE,
      IRRS_RAISE,
      IRRS_SETUP,
      IRRS_HOLD,
      IRRS_DONE
   } irrs_state_t;

   // Pins toward the transceiver
   typedef struct packed {
      logic txd;
      logic shutdown_rate_prog_in;
      logic rate_pin_out;
      logic rate_pin_oe;
   } irrs_pins_t;
endpackage

// [irrs_host.sv]
`timescale 1ns/1ps
module irrs_host (
   // Clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_rst_n,
   // Command
   input  wire logic              i_prog_start,
   input  wire logic              i_prog_high,
   input  wire logic              i_static_en,
   input  wire logic              i_static_high,
   input  wire logic              i_shutdown,
   input  wire logic              i_tx_data,
   // Status
   output logic                   o_busy,
   output logic                   o_mode_valid,
   output logic                   o_mode_high,
   // Transceiver pins
   output irrs_pkg::irrs_pins_t   o_pins
);
   import irrs_pkg::*;

   // Refuse timing counts that the down-counter cannot hold
   if (SETUP_CYC < 1 || HOLD_CYC < 1 || HIGH_CYC < 1 ||
       SETUP_CYC > 15 || HOLD_CYC > 15 || HIGH_CYC > 15) begin : g_bad_timing
      $error("irrs_host: timing counts out of range");
   end

   irrs_state_t      state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic             req_reg, req_next;
   logic             valid_reg, valid_next;
   logic             mhigh_reg, mhigh_next;
   irrs_pins_t       pins_reg, pins_next;

   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      req_next   = req_reg;
      valid_next = valid_reg;
      mhigh_next = mhigh_reg;
      pins_next  = pins_reg;
      // Static pin drives only when enabled and not in shutdown, floats otherwise
      pins_next.rate_pin_oe  = i_static_en && !i_shutdown;
      pins_next.rate_pin_out = i_static_high;
      case (state_reg)
         IRRS_IDLE: begin
            pins_next.shutdown_rate_prog_in = i_shutdown;
            pins_next.txd     = (valid_reg && !i_shutdown) ? i_tx_data : 1'b0;
            if (i_static_en) begin
               valid_next = 1'b1;
               mhigh_next = i_static_high;
            end
            if (i_prog_start) begin
               req_next          = i_prog_high;
               pins_next.shutdown_rate_prog_in = 1'b1;
               pins_next.txd     = 1'b0;
               cnt_next          = HIGH_CYC[CNT_W-1:0];
               state_next        = IRRS_RAISE;
            end
         end
         IRRS_RAISE: begin
            if (cnt_reg <= 4'h1) begin
               pins_next.txd = req_reg;
               cnt_next      = SETUP_CYC[CNT_W-1:0];
               state_next    = IRRS_SETUP;
            end else begin
               cnt_next = cnt_reg - 4'h1;
            end
         end
         IRRS_SETUP: begin
            if (cnt_reg <= 4'h1) begin
               pins_next.shutdown_rate_prog_in = 1'b0;
               cnt_next          = HOLD_CYC[CNT_W-1:0];
               state_next        = IRRS_HOLD;
            end else begin
               cnt_next = cnt_reg - 4'h1;
            end
         end
         IRRS_HOLD: begin
            if (cnt_reg <= 4'h1) begin
               pins_next.txd = 1'b0;
               valid_next    = 1'b1;
               mhigh_next    = req_reg;
               state_next    = IRRS_DONE;
            end else begin
               cnt_next = cnt_reg - 4'h1;
            end
         end
         IRRS_DONE: begin
            cnt_next   = CNT_ZERO;
            state_next = IRRS_IDLE;
         end
         default: begin
            state_next = IRRS_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         state_reg <= IRRS_IDLE;
         cnt_reg   <= CNT_ZERO;
         req_reg   <= MODE_LOW;
         valid_reg <= 1'b0;
         mhigh_reg <= MODE_LOW;
         pins_reg  <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         req_reg   <= req_next;
         valid_reg <= valid_next;
         mhigh_reg <= mhigh_next;
         pins_reg  <= pins_next;
      end
   end

   logic busy_reg;
   always_ff @(posedge i_clk) begin
      if (!i_rst_n)
         busy_reg <= 1'b0;
      else
         busy_reg <= (state_next != IRRS_IDLE);
   end

   assign o_busy       = busy_reg;
   assign o_mode_valid = valid_reg;
   assign o_mode_high  = mhigh_reg;
   assign o_pins       = pins_reg;
endmodule

// [irrs_props.sv]
`timescale 1ns/1ps
module irrs_props (
   // Watched ports
   input wire logic                 i_clk,
   input wire logic                 i_rst_n,
   input wire logic                 i_static_en,
   input wire logic                 o_busy,
   input wire logic                 o_mode_valid,
   input wire logic                 o_mode_high,
   input wire irrs_pkg::irrs_pins_t o_pins
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   sequence s_fall; o_busy && $fell(o_pins.shutdown_rate_prog_in); endsequence
   a_sd_first: assert property ($rose(o_busy) |-> o_pins.shutdown_rate_prog_in ##5
      o_pins.shutdown_rate_prog_in ##5 s_fall) else $error("order");
   a_setup_held: assert property (s_fall |-> $past(o_pins.txd, 5) == o_pins.txd)
      else $error("setup");
   a_hold_kept: assert property (s_fall |=> $stable(o_pins.txd)[*4])
      else $error("hold");
   a_mode_set: assert property (s_fall ##0 !i_static_en |-> ##5 o_mode_valid &&
      o_mode_high == $past(o_pins.txd, 5)) else $error("mode");
   a_tx_quiet: assert property (!o_mode_valid && !o_busy |-> !o_pins.txd)
      else $error("tx");
   a_rate_float: assert property (!i_static_en |=> !o_pins.rate_pin_oe)
      else $error("pin");
endmodule
bind irrs_host irrs_props props_u (.*);

// [irrs_dev.sv]
`timescale 1ns/1ps
module irrs_dev (
   // Host pins in, device state out
   input  wire irrs_pkg::irrs_pins_t i_pins,
   output logic                      o_high,
   output logic                      o_rx_on
);
   logic latched = 1'b0;
   always @(negedge i_pins.shutdown_rate_prog_in) latched = i_pins.txd;
   assign o_high = i_pins.rate_pin_oe ? i_pins.rate_pin_out : latched;
   assign o_rx_on = !i_pins.shutdown_rate_prog_in;
endmodule

// [irrs_host_bench.sv]
`timescale 1ns/1ps
module irrs_host_bench;
   logic                 clk = 1'b0;
   logic [6:0]           cmd = 7'h01;
   logic                 busy, valid, mhigh, xhigh, rx;
   irrs_pkg::irrs_pins_t pins;
   int                   mismatches = 0, checks_done = 0, n;
   irrs_host dut (.i_clk(clk), .i_rst_n(cmd[6]), .i_prog_start(cmd[5]), .i_prog_high(cmd[4]),
      .i_static_en(cmd[3]), .i_static_high(cmd[2]), .i_shutdown(cmd[1]), .i_tx_data(cmd[0]),
      .o_busy(busy), .o_mode_valid(valid), .o_mode_high(mhigh), .o_pins(pins));
   irrs_dev dev (.i_pins(pins), .o_high(xhigh), .o_rx_on(rx));
   initial forever #20 clk = ~clk;
   task automatic chk(input logic [3:0] s, input logic [3:0] e);
      checks_done++;
      mismatches += int'(s !== e);
      if (s !== e) $display("wrong value at %0t: %h expected %h", $time, s, e);
   endtask
   task automatic report_and_stop;
      if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic prog(input logic hi);
      cmd[5:4] = {1'b1, hi};
      repeat (2) @(negedge clk);
      cmd[5] = 1'b0;
      for (n = 0; n < 30 && busy === 1'b1; n++) @(negedge clk);
      chk({busy, valid, mhigh, xhigh}, {2'h1, hi, hi});
      if (n == 30) report_and_stop();
   endtask
   task automatic static_rate(input logic hi);
      cmd[3:2] = {1'b1, hi};
      repeat (2) @(negedge clk);
      chk({pins.rate_pin_oe, pins.rate_pin_out, xhigh, valid}, {1'b1, hi, hi, 1'b1});
   endtask
   initial begin
      repeat (20) @(negedge clk);
      cmd[6] = 1'b1;
      repeat (3) @(negedge clk);
      chk({2'h0, valid, pins.txd}, 4'h0);
      for (int m = 0; m < 3; m++) prog(!m[0]);
      for (int m = 0; m < 2; m++) static_rate(m[0]);
      cmd[3:1] = 3'h1;
      repeat (2) @(negedge clk);
      chk({pins.rate_pin_oe, rx, xhigh, pins.txd}, 4'h2);
      report_and_stop();
   end
endmodule
